/* File: logic/pfbm_consts.vh */
// timing figures and address layout for the parallel flash bus host
`ifndef PFBM_CONSTS_VH
`define PFBM_CONSTS_VH

// --------------------------------------------------------------------------
// clock in megahertz and timing figures in nanoseconds
// --------------------------------------------------------------------------
`define PFBM_CLK_MHZ 250
`define PFBM_T_ACC_NS 100
`define PFBM_T_PAGE_NS 40
`define PFBM_T_RP_NS 500
`define PFBM_T_RH_NS 200
`define PFBM_T_WE_NS 50
`define PFBM_T_WSU_NS 20
`define PFBM_T_PROT_NS 100000

// --------------------------------------------------------------------------
// address layout
// --------------------------------------------------------------------------
`define PFBM_AW 22
`define PFBM_DW 16
`define PFBM_PAGE_LSB 2
`define PFBM_ID_BITS 7
`define PFBM_GRP_LSB 17
`define PFBM_GRP_W 5
`define PFBM_PROT_LOW 7'h02

// --------------------------------------------------------------------------
// host operation codes
// --------------------------------------------------------------------------
`define PFBM_OP_READ 3'h0
`define PFBM_OP_WRITE 3'h1
`define PFBM_OP_IDREAD 3'h2
`define PFBM_OP_PROTECT 3'h3
`define PFBM_OP_VERIFY 3'h4
`define PFBM_OP_RESET 3'h5
`define PFBM_OP_STANDBY 3'h6

`endif

/* File: logic/pfbm_timer.v */
// down counter that raises a one-cycle done pulse after a loaded number of cycles
module pfbm_timer #(
    parameter W = 16
) (
    // clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // load and completion
    input wire load_i,
    input wire [W-1:0] count_i,
    output reg done_o
);
    reg [W-1:0] cnt_reg;

    // a zero count never fires; the host always loads at least one
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            cnt_reg <= {W{1'b0}};
            done_o <= 1'b0;
        end else if (load_i) begin
            cnt_reg <= count_i;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
            if (cnt_reg != {W{1'b0}}) begin
                cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // pfbm_timer

/* File: logic/pfbm_host.v */
// host controller that drives a 16-bit parallel flash through its pins
//
// How it works
// - id mode: bit nine high voltage, low seven decode
// - command write: we low, ce low, oe high
// - protect: high voltage on bit nine and oe, we pulse
// - verify: pattern 0,0,0,1,0, data bit zero shows protection
// - reset low at least the minimum pulse time
// - wait release delay before reading after reset
`include "pfbm_consts.vh"

module pfbm_host #(
    parameter AW = `PFBM_AW,
    parameter DW = `PFBM_DW,
    parameter TW = 16,
    parameter PROT_CYC = ((`PFBM_T_PROT_NS * `PFBM_CLK_MHZ) + 999) / 1000
) (
    // clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // command port
    input wire req_i,
    input wire [2:0] op_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] wdata_i,
    input wire unprotect_i,
    output wire ready_o,
    output reg done_o,
    output reg [DW-1:0] rdata_o,
    // flash pins
    output reg [AW-1:0] addr_o,
    output reg ce_n_o,
    output reg oe_n_o,
    output reg we_n_o,
    output reg reset_n_o,
    input wire [DW-1:0] dq_i,
    output reg [DW-1:0] dq_o,
    output reg dq_oe_n_o,
    // high voltage switch requests
    output reg address_bit_nine_hv_o,
    output reg oe_hv_o,
    output reg reset_hv_o
);
    // ----------------------------------------------------------------------
    // cycle counts
    // ----------------------------------------------------------------------
    // least times round up to whole cycles, never below one
    function [TW-1:0] ns2cyc;
        input integer ns;
        integer c;
        begin
            c = (ns * `PFBM_CLK_MHZ + 999) / 1000;
            if (c < 1) begin
                c = 1;
            end
            ns2cyc = c[TW-1:0];
        end
    endfunction

    localparam [TW-1:0] ACC_CYC = ns2cyc(`PFBM_T_ACC_NS);
    localparam [TW-1:0] PAGE_CYC = ns2cyc(`PFBM_T_PAGE_NS);
    localparam [TW-1:0] RP_CYC = ns2cyc(`PFBM_T_RP_NS);
    localparam [TW-1:0] RH_CYC = ns2cyc(`PFBM_T_RH_NS);
    localparam [TW-1:0] WE_CYC = ns2cyc(`PFBM_T_WE_NS);
    localparam [TW-1:0] WSU_CYC = ns2cyc(`PFBM_T_WSU_NS);
    localparam [TW-1:0] PROT_CNT = PROT_CYC[TW-1:0];

    // ----------------------------------------------------------------------
    // states
    // ----------------------------------------------------------------------
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_RST_LO = 8'h02;
    localparam [7:0] S_RST_HI = 8'h04;
    localparam [7:0] S_RD = 8'h08;
    localparam [7:0] S_WR_SU = 8'h10;
    localparam [7:0] S_WR_LO = 8'h20;
    localparam [7:0] S_WR_HI = 8'h40;
    localparam [7:0] S_PROT = 8'h80;

    reg [7:0] state_reg;
    reg tmr_load_reg;
    reg [TW-1:0] tmr_cnt_reg;
    reg page_open_reg;
    reg [AW-1:0] last_addr_reg;
    reg [2:0] op_reg;
    wire tmr_done;
    wire same_page;

    pfbm_timer #(.W(TW)) u_timer (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .load_i(tmr_load_reg),
        .count_i(tmr_cnt_reg),
        .done_o(tmr_done)
    );

    // request accepted only in idle; busy work is interrupted only by reset_i
    assign ready_o = (state_reg == S_IDLE);
    // in-page read only while the last plain read left the chip selected
    assign same_page = page_open_reg &&
        (addr_i[AW-1:`PFBM_PAGE_LSB] == last_addr_reg[AW-1:`PFBM_PAGE_LSB]);

    // ----------------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------------
    // after own reset the flash is pulsed into read mode before any request
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg <= S_RST_LO;
            tmr_load_reg <= 1'b1;
            tmr_cnt_reg <= RP_CYC;
            page_open_reg <= 1'b0;
            last_addr_reg <= {AW{1'b0}};
            op_reg <= `PFBM_OP_READ;
            done_o <= 1'b0;
            rdata_o <= {DW{1'b0}};
            addr_o <= {AW{1'b0}};
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            reset_n_o <= 1'b0;
            dq_o <= {DW{1'b0}};
            dq_oe_n_o <= 1'b1;
            address_bit_nine_hv_o <= 1'b0;
            oe_hv_o <= 1'b0;
            reset_hv_o <= 1'b0;
        end else begin
            tmr_load_reg <= 1'b0;
            done_o <= 1'b0;
            // high voltage on reset only while reset is released
            reset_hv_o <= unprotect_i && reset_n_o;
            case (state_reg)
                S_IDLE: begin
                    if (req_i) begin
                        op_reg <= op_i;
                        tmr_load_reg <= 1'b1;
                        case (op_i)
                            `PFBM_OP_READ, `PFBM_OP_IDREAD, `PFBM_OP_VERIFY: begin
                                // address held stable afterwards lets the flash nap
                                addr_o <= addr_i;
                                ce_n_o <= 1'b0;
                                oe_n_o <= 1'b0;
                                we_n_o <= 1'b1;
                                dq_oe_n_o <= 1'b1;
                                address_bit_nine_hv_o <= (op_i != `PFBM_OP_READ);
                                oe_hv_o <= 1'b0;
                                if (op_i == `PFBM_OP_IDREAD) begin
                                    // only the low seven bits pick the id word
                                    addr_o <= {{(AW-`PFBM_ID_BITS){1'b0}},
                                        addr_i[`PFBM_ID_BITS-1:0]};
                                end else if (op_i == `PFBM_OP_VERIFY) begin
                                    addr_o <= {addr_i[AW-1:`PFBM_ID_BITS], `PFBM_PROT_LOW};
                                end
                                tmr_cnt_reg <= (op_i == `PFBM_OP_READ && same_page) ?
                                    PAGE_CYC : ACC_CYC;
                                state_reg <= S_RD;
                            end
                            `PFBM_OP_WRITE, `PFBM_OP_PROTECT: begin
                                // oe goes high first so the flash lets go of the bus
                                page_open_reg <= 1'b0;
                                ce_n_o <= 1'b0;
                                oe_n_o <= 1'b1;
                                we_n_o <= 1'b1;
                                address_bit_nine_hv_o <= (op_i == `PFBM_OP_PROTECT);
                                oe_hv_o <= (op_i == `PFBM_OP_PROTECT);
                                if (op_i == `PFBM_OP_PROTECT) begin
                                    addr_o <= {addr_i[AW-1:`PFBM_ID_BITS], `PFBM_PROT_LOW};
                                end else begin
                                    addr_o <= addr_i;
                                end
                                dq_o <= wdata_i;
                                tmr_cnt_reg <= WSU_CYC;
                                state_reg <= S_WR_SU;
                            end
                            `PFBM_OP_RESET: begin
                                page_open_reg <= 1'b0;
                                ce_n_o <= 1'b1;
                                oe_n_o <= 1'b1;
                                dq_oe_n_o <= 1'b1;
                                address_bit_nine_hv_o <= 1'b0;
                                oe_hv_o <= 1'b0;
                                reset_n_o <= 1'b0;
                                reset_hv_o <= 1'b0;
                                tmr_cnt_reg <= RP_CYC;
                                state_reg <= S_RST_LO;
                            end
                            default: begin
                                // standby: chip deselected with reset high
                                page_open_reg <= 1'b0;
                                ce_n_o <= 1'b1;
                                oe_n_o <= 1'b1;
                                address_bit_nine_hv_o <= 1'b0;
                                oe_hv_o <= 1'b0;
                                tmr_load_reg <= 1'b0;
                                done_o <= 1'b1;
                            end
                        endcase
                    end
                end
                S_RST_LO: begin
                    if (tmr_done) begin
                        reset_n_o <= 1'b1;
                        tmr_load_reg <= 1'b1;
                        tmr_cnt_reg <= RH_CYC;
                        state_reg <= S_RST_HI;
                    end
                end
                S_RST_HI: begin
                    // no read leaves idle until the release delay is over
                    if (tmr_done) begin
                        done_o <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                S_RD: begin
                    if (tmr_done) begin
                        rdata_o <= (op_reg == `PFBM_OP_VERIFY) ?
                            {{(DW-1){1'b0}}, dq_i[0]} : dq_i;
                        done_o <= 1'b1;
                        last_addr_reg <= addr_o;
                        // plain reads keep the page open; high voltage modes end it
                        page_open_reg <= (op_reg == `PFBM_OP_READ);
                        if (op_reg != `PFBM_OP_READ) begin
                            ce_n_o <= 1'b1;
                            oe_n_o <= 1'b1;
                            address_bit_nine_hv_o <= 1'b0;
                        end
                        state_reg <= S_IDLE;
                    end
                end
                S_WR_SU: begin
                    if (tmr_done) begin
                        // we falls after ce, so its fall latches the address
                        we_n_o <= 1'b0;
                        dq_oe_n_o <= (op_reg == `PFBM_OP_PROTECT);
                        tmr_load_reg <= 1'b1;
                        tmr_cnt_reg <= (op_reg == `PFBM_OP_PROTECT) ? PROT_CNT : WE_CYC;
                        state_reg <= S_WR_LO;
                    end
                end
                S_WR_LO: begin
                    if (tmr_done) begin
                        // we rises before ce, so its rise latches the data
                        we_n_o <= 1'b1;
                        tmr_load_reg <= 1'b1;
                        tmr_cnt_reg <= WSU_CYC;
                        state_reg <= (op_reg == `PFBM_OP_PROTECT) ? S_PROT : S_WR_HI;
                    end
                end
                S_WR_HI, S_PROT: begin
                    // address and data held past the we rise before letting go
                    if (tmr_done) begin
                        ce_n_o <= 1'b1;
                        dq_oe_n_o <= 1'b1;
                        address_bit_nine_hv_o <= 1'b0;
                        oe_hv_o <= 1'b0;
                        done_o <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule // pfbm_host

/* File: dv/pfbm_sva.sv */
// checker on the pins of the parallel flash host
module pfbm_sva (
    // clock and reset
    input logic ref_clk_i,
    input logic reset_i,
    // command port
    input logic req_i,
    input logic [2:0] op_i,
    input logic ready_o,
    input logic done_o,
    // flash pins
    input logic [21:0] addr_o,
    input logic ce_n_o,
    input logic oe_n_o,
    input logic we_n_o,
    input logic reset_n_o,
    input logic dq_oe_n_o,
    input logic address_bit_nine_hv_o,
    input logic oe_hv_o,
    input logic reset_hv_o
);
    localparam int RP_CYC = 125;
    localparam int RH_CYC = 50;
    logic [7:0] lo_cnt;
    logic [7:0] hi_cnt;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // ----------------------------------------
    // reset pin timing
    // ----------------------------------------
    // saturating counts of reset pin low and high time
    always @(posedge ref_clk_i) begin
        lo_cnt <= (reset_i || reset_n_o) ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
        hi_cnt <= (reset_i || !reset_n_o) ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
    end
    property p_reset_pins; disable iff (1'b0) reset_i |=> ce_n_o && !reset_n_o && dq_oe_n_o; endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins not idle in reset");
    property p_rp_min; $rose(reset_n_o) |-> lo_cnt >= RP_CYC; endproperty
    a_rp_min: assert property (p_rp_min) else $error("reset pulse too short");
    property p_rh_wait; !oe_n_o |-> reset_n_o && hi_cnt >= RH_CYC; endproperty
    a_rh_wait: assert property (p_rh_wait) else $error("read too soon after reset");
    property p_unprot; reset_hv_o |-> reset_n_o; endproperty
    a_unprot: assert property (p_unprot) else $error("high voltage with reset low");
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    property p_write_combo; !we_n_o |-> !ce_n_o && (oe_n_o || oe_hv_o); endproperty
    a_write_combo: assert property (p_write_combo) else $error("write strobe outside select");
    property p_no_clash; !dq_oe_n_o |-> oe_n_o; endproperty
    a_no_clash: assert property (p_no_clash) else $error("host drives data with output on");
    property p_ce_first; $fell(we_n_o) |-> !$past(ce_n_o); endproperty
    a_ce_first: assert property (p_ce_first) else $error("select after strobe fall");
    // a protect pulse carries no data, so only plain writes must drive the bus at the rise
    property p_we_rise; $rose(we_n_o) |-> !ce_n_o && (oe_hv_o || !dq_oe_n_o); endproperty
    a_we_rise: assert property (p_we_rise) else $error("data gone at strobe rise");
    property p_prot_hold;
        !we_n_o && oe_hv_o |-> address_bit_nine_hv_o && addr_o[6:0] == 7'h02 ##1 (we_n_o || $stable(addr_o[21:17]));
    endproperty
    a_prot_hold: assert property (p_prot_hold) else $error("bad protect cycle");
    // in-page read shows done 13 edges after the request, a full access 28 edges after
    property p_read_time; ready_o && req_i && op_i == 3'h0 |=> !done_o [*8] ##[5:20] done_o; endproperty
    a_read_time: assert property (p_read_time) else $error("read length wrong");
    property p_done_pulse; done_o |=> !done_o; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
endmodule // pfbm_sva

/* File: dv/pfbm_flash_model.sv */
// behavioural model of the 16-bit parallel flash
module pfbm_flash_model #(
    parameter int ACC_LAT = 20,
    parameter int PG_LAT = 6,
    parameter logic [15:0] MAKER = 16'h00a1, // arbitrary value
    parameter logic [15:0] DEVICE = 16'h5c3d, // arbitrary value
    parameter logic [15:0] ID_CMD = 16'h00c5 // arbitrary value
) (
    // clock
    input logic ref_clk_i,
    // pins from the host
    input logic [21:0] addr_i,
    input logic ce_n_i,
    input logic oe_n_i,
    input logic we_n_i,
    input logic reset_n_i,
    input logic [15:0] dq_i,
    input logic dq_oe_n_i,
    input logic address_bit_nine_hv_i,
    input logic oe_hv_i,
    input logic reset_hv_i,
    // data to the host
    output logic [15:0] dq_o
);
    logic [15:0] mem [16];
    logic [31:0] prot = 32'h0;
    logic [21:0] last;
    logic [21:0] wa;
    logic [7:0] cnt = 8'h00;
    logic pg = 1'b0;
    logic sel_q = 1'b0;
    logic id_mode = 1'b0;
    wire sel = !ce_n_i && !we_n_i;
    wire valid = cnt >= (pg ? PG_LAT : ACC_LAT);
    // id words decode the low seven address bits; the protection word also uses bits 21 to 17
    wire [15:0] id_word = addr_i[6:0] == 7'h00 ? MAKER : addr_i[6:0] == 7'h01 ? DEVICE :
        addr_i[6:0] == 7'h02 ? {15'h0000, prot[addr_i[21:17]]} : 16'h0000;
    initial begin
        dq_o = 16'h0000;
        for (int i = 0; i < 16; i++) mem[i] = {12'hc3a, i[3:0]};
    end
    // ----------------------------------------
    // read path
    // ----------------------------------------
    // a released bus shows a changing pattern, so a read taken early never looks right by luck
    always @(posedge ref_clk_i) begin
        last <= addr_i;
        cnt <= (addr_i != last || ce_n_i || oe_n_i) ? 8'h00 : cnt + {7'h00, !valid};
        if (addr_i != last) pg <= valid && addr_i[21:2] == last[21:2];
        if (ce_n_i || oe_n_i || !reset_n_i || !we_n_i) begin
            dq_o <= ~dq_o;
            pg <= 1'b0;
        end else begin
            dq_o <= !valid ? ~dq_o : (address_bit_nine_hv_i || id_mode) ? id_word : mem[addr_i[3:0]];
        end
    end
    // ----------------------------------------
    // write and protect path
    // ----------------------------------------
    // address on the later falling edge, data on the first rising edge
    always @(posedge ref_clk_i) begin
        sel_q <= sel;
        if (sel && !sel_q) wa <= addr_i;
        if (!reset_n_i) begin
            id_mode <= 1'b0;
        end else if (!sel && sel_q && (oe_n_i || oe_hv_i)) begin
            if (address_bit_nine_hv_i && oe_hv_i && addr_i[21:17] == wa[21:17]) begin
                prot[wa[21:17]] <= 1'b1;
            end else if (id_mode || dq_i == ID_CMD) begin
                // the id command enters id mode without high voltage; any later write leaves it
                id_mode <= !id_mode;
            end else if (!prot[wa[21:17]] || reset_hv_i) begin
                mem[wa[3:0]] <= mem[wa[3:0]] & (dq_oe_n_i ? 16'hffff : dq_i);
            end
        end
    end
endmodule // pfbm_flash_model

/* File: dv/pfbm_host_bench.sv */
// self-checking bench for the parallel flash host
`include "pfbm_consts.vh"
module pfbm_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] op; logic [21:0] a; logic [15:0] d; logic u; logic c; logic [15:0] e;} pfbm_row_t;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_i = 1'b0;
    logic [2:0] op_i = 3'h0;
    logic [21:0] addr_i = 22'h0;
    logic [15:0] wdata_i = 16'h0;
    logic unprotect_i = 1'b0;
    wire ready_o, done_o, ce_n_o, oe_n_o, we_n_o, reset_n_o, dq_oe_n_o;
    wire address_bit_nine_hv_o, oe_hv_o, reset_hv_o;
    wire [15:0] rdata_o, dq_i, dq_o;
    wire [21:0] addr_o;
    int num_errors = 0;
    int total_checks = 0;
    // ordinary cases: op, address, data, unprotect, compare, expected read data
    pfbm_row_t rows [21] = '{
        '{`PFBM_OP_READ, 22'h000005, 16'h0, 0, 1, 16'hc3a5}, '{`PFBM_OP_READ, 22'h000006, 16'h0, 0, 1, 16'hc3a6},
        '{`PFBM_OP_WRITE, 22'h000005, 16'h0f0f, 0, 0, 16'h0}, '{`PFBM_OP_READ, 22'h000005, 16'h0, 0, 1, 16'h0305},
        '{`PFBM_OP_IDREAD, 22'h3fff80, 16'h0, 0, 1, 16'h00a1}, '{`PFBM_OP_IDREAD, 22'h000001, 16'h0, 0, 1, 16'h5c3d},
        '{`PFBM_OP_VERIFY, 22'h060000, 16'h0, 0, 1, 16'h0000}, '{`PFBM_OP_PROTECT, 22'h060000, 16'h0, 0, 0, 16'h0},
        '{`PFBM_OP_VERIFY, 22'h060000, 16'h0, 0, 1, 16'h0001}, '{`PFBM_OP_VERIFY, 22'h080000, 16'h0, 0, 1, 16'h0000},
        '{`PFBM_OP_WRITE, 22'h060009, 16'h0, 0, 0, 16'h0}, '{`PFBM_OP_READ, 22'h060009, 16'h0, 0, 1, 16'hc3a9},
        '{`PFBM_OP_WRITE, 22'h060009, 16'h00ff, 1, 0, 16'h0}, '{`PFBM_OP_READ, 22'h060009, 16'h0, 0, 1, 16'h00a9},
        '{`PFBM_OP_RESET, 22'h0, 16'h0, 0, 0, 16'h0}, '{`PFBM_OP_READ, 22'h000002, 16'h0, 0, 1, 16'hc3a2},
        '{`PFBM_OP_STANDBY, 22'h0, 16'h0, 0, 0, 16'h0}, '{`PFBM_OP_READ, 22'h000003, 16'h0, 0, 1, 16'hc3a3},
        '{`PFBM_OP_WRITE, 22'h000000, 16'h00c5, 0, 0, 16'h0}, '{`PFBM_OP_READ, 22'h000001, 16'h0, 0, 1, 16'h5c3d},
        '{`PFBM_OP_WRITE, 22'h000000, 16'h0000, 0, 0, 16'h0}};
    pfbm_host #(.PROT_CYC(8)) u_pfbm_host (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i), .op_i(op_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .unprotect_i(unprotect_i), .ready_o(ready_o), .done_o(done_o),
        .rdata_o(rdata_o), .addr_o(addr_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
        .reset_n_o(reset_n_o), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
        .address_bit_nine_hv_o(address_bit_nine_hv_o), .oe_hv_o(oe_hv_o), .reset_hv_o(reset_hv_o));
    pfbm_flash_model u_pfbm_flash_model (.ref_clk_i(ref_clk_i), .addr_i(addr_o), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
        .we_n_i(we_n_o), .reset_n_i(reset_n_o), .dq_i(dq_o), .dq_oe_n_i(dq_oe_n_o),
        .address_bit_nine_hv_i(address_bit_nine_hv_o), .oe_hv_i(oe_hv_o), .reset_hv_i(reset_hv_o), .dq_o(dq_i));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always #2 ref_clk_i = ~ref_clk_i;
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one request, then a bounded wait for completion
    task do_op(input logic [2:0] op, input logic [21:0] a, input logic [15:0] d, input logic u);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (ready_o !== 1'b1 && n < 2000) begin @(negedge ref_clk_i); n++; end
        req_i = 1'b1; op_i = op; addr_i = a; wdata_i = d; unprotect_i = u;
        @(negedge ref_clk_i);
        req_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 2000) begin @(negedge ref_clk_i); n++; end
        check("done", {15'h0, done_o}, 16'h0001);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // a full run costs far less than this span, so reaching it means a stuck handshake
    initial begin
        #200000;
        num_errors++;
        end_sim;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(negedge ref_clk_i);
        reset_i = 1'b0;
        for (int i = 0; i < 21; i++) begin
            do_op(rows[i].op, rows[i].a, rows[i].d, rows[i].u);
            if (rows[i].c) check("rdata", rdata_o, rows[i].e);
            $display("row %0d done", i);
        end
        // reset in mid read, then a request while not ready must be dropped
        req_i = 1'b1; op_i = `PFBM_OP_READ; addr_i = 22'h000005;
        @(negedge ref_clk_i);
        req_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        reset_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check("pins", {12'h0, ce_n_o, reset_n_o, dq_oe_n_o, ready_o}, 16'h000a);
        reset_i = 1'b0;
        @(negedge ref_clk_i);
        req_i = 1'b1; op_i = `PFBM_OP_WRITE; wdata_i = 16'h0;
        @(negedge ref_clk_i);
        req_i = 1'b0;
        do_op(`PFBM_OP_READ, 22'h000005, 16'h0, 1'b0);
        check("rdata", rdata_o, 16'h0305);
        $display("reset test done");
        end_sim;
    end
endmodule // pfbm_host_bench
bind pfbm_host pfbm_sva u_pfbm_sva (.ref_clk_i, .reset_i, .req_i, .op_i, .ready_o, .done_o, .addr_o, .ce_n_o,
    .oe_n_o, .we_n_o, .reset_n_o, .dq_oe_n_o, .address_bit_nine_hv_o, .oe_hv_o, .reset_hv_o);
